/* rtl/lcad_pkg.sv */
// Constants and types of the command/address decoder
package lcad_pkg;
  localparam int CA_W  = 10;
  localparam int ROW_W = 13;
  localparam int COL_W = 8;
  localparam int BANKS = 4;
  localparam int BA_W  = 2;
  localparam int DQ_W  = 32;
  localparam int LANES = 4;
  localparam int BCNT_W = 5;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_ROW    = 8'h0C;
  localparam logic [7:0] OFS_MODE   = 8'h10;

  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_BL_LSB = 1;
  localparam logic       CTRL_EN_RST = 1'h1;
  localparam logic [1:0] CTRL_BL_RST = 2'h1;

  localparam int ST_PWR_LSB  = 0;
  localparam int ST_OPEN_LSB = 2;
  localparam int ST_BUR_LSB  = 6;
  localparam int ST_CKE_POS  = 8;
  localparam int CMD_BA_LSB  = 4;
  localparam int CMD_COL_LSB = 6;
  localparam int CMD_AP_POS  = 14;
  localparam int ROW_BA_LSB  = 13;
  localparam int MODE_OP_LSB = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [BCNT_W-1:0] BL4  = 5'h04;
  localparam logic [BCNT_W-1:0] BL8  = 5'h08;
  localparam logic [BCNT_W-1:0] BL16 = 5'h10;

  typedef enum logic [1:0] {
    PWR_ON  = 2'h0,
    PWR_PD  = 2'h1,
    PWR_SR  = 2'h3,
    PWR_DPD = 2'h2
  } lcad_pwr_e;

  typedef enum logic [1:0] {
    BUR_IDLE = 2'h0,
    BUR_RD   = 2'h1,
    BUR_WR   = 2'h3
  } lcad_bur_e;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_MRW = 4'h1,
    CMD_MRR = 4'h2,
    CMD_REF = 4'h3,
    CMD_ACT = 4'h4,
    CMD_WR  = 4'h5,
    CMD_RD  = 4'h6,
    CMD_PRE = 4'h7,
    CMD_BST = 4'h8
  } lcad_cmd_e;
endpackage

/* rtl/lcad_decoder.sv */
// Command/address decoder, power-state tracker and data lanes of a DDR mobile DRAM
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module lcad_decoder (
  input  logic                                       aclk,
  input  logic                                       aresetn,
  input  logic [7:0]                                 s_axi_awaddr,
  input  logic [2:0]                                 s_axi_awprot,
  input  logic                                       s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  logic [31:0]                                s_axi_wdata,
  input  logic [3:0]                                 s_axi_wstrb,
  input  logic                                       s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  logic                                       s_axi_bready,
  input  logic [7:0]                                 s_axi_araddr,
  input  logic [2:0]                                 s_axi_arprot,
  input  logic                                       s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  logic                                       s_axi_rready,
  input  logic                                       ck,
  input  logic                                       cke,
  input  logic                                       cs_n,
  input  logic [lcad_pkg::CA_W-1:0]                  ca,
  input  logic [lcad_pkg::DQ_W-1:0]                  dq_i,
  output logic [lcad_pkg::DQ_W-1:0]                  dq_o,
  output logic                                       dq_oe,
  input  logic [lcad_pkg::LANES-1:0]                 dqs_i,
  output logic [lcad_pkg::LANES-1:0]                 dqs_o,
  output logic [lcad_pkg::LANES-1:0]                 dqs_oe,
  input  logic [lcad_pkg::LANES-1:0]                 dm,
  output logic                                       clk_active,
  output logic [1:0]                                 pwr_state,
  output logic                                       cmd_valid,
  output logic [3:0]                                 cmd_code,
  output logic [lcad_pkg::BA_W-1:0]                  cmd_bank,
  output logic [lcad_pkg::ROW_W-1:0]                 cmd_row,
  output logic [lcad_pkg::COL_W-1:0]                 cmd_col,
  output logic                                       cmd_ap,
  output logic [7:0]                                 mr_addr,
  output logic [7:0]                                 mr_op,
  output logic                                       pre_valid,
  output logic [lcad_pkg::BANKS-1:0]                 pre_banks,
  output logic                                       wr_valid,
  output logic [lcad_pkg::DQ_W-1:0]                  wr_data,
  output logic [lcad_pkg::LANES-1:0]                 wr_be,
  output logic [lcad_pkg::COL_W-1:0]                 wr_col,
  output logic [lcad_pkg::BA_W-1:0]                  burst_bank,
  output logic                                       rd_req,
  output logic [lcad_pkg::COL_W-1:0]                 rd_col,
  input  logic [2*lcad_pkg::DQ_W-1:0]                rd_word
);
  import lcad_pkg::*;

  typedef struct packed {
    logic                         ck_m, ck_s, ck_d;
    logic                         cke_m, cke_s, cs_m, cs_s;
    logic [CA_W-1:0]              ca_m, ca_s;
    logic [LANES-1:0]             dqs_m, dqs_s, dqs_d, dm_m, dm_s;
    logic [DQ_W-1:0]              dq_m, dq_s;
    logic [CA_W-1:0]              ca_r;
    logic                         cs_r, cke_r, cke_p;
    lcad_pwr_e                    pwr;
    logic [BANKS-1:0]             open;
    logic [BANKS-1:0][ROW_W-1:0]  rows;
    logic                         cmd_vld;
    lcad_cmd_e                    cmd;
    logic [BA_W-1:0]              bank;
    logic [ROW_W-1:0]             row;
    logic [BA_W-1:0]              row_bank;
    logic [COL_W-1:0]             col;
    logic                         ap;
    logic [7:0]                   mra, mrop;
    logic                         pre_vld;
    logic [BANKS-1:0]             pre_mask;
    lcad_bur_e                    bur;
    logic [BA_W-1:0]              bbank;
    logic                         bap;
    logic [COL_W-1:0]             bcol;
    logic [BCNT_W-1:0]            bcnt;
    logic [2*DQ_W-1:0]            rdw;
    logic [DQ_W-1:0]              dq_o;
    logic                         dq_oe, dqs_o;
    logic                         wr_vld;
    logic [DQ_W-1:0]              wr_data;
    logic [LANES-1:0]             wr_be;
    logic [COL_W-1:0]             wr_col, rd_col;
    logic                         rd_req;
    logic                         ctrl_en;
    logic [1:0]                   ctrl_bl;
    logic                         aw_got, w_got;
    logic [7:0]                   awaddr;
    logic [31:0]                  wdata;
    logic [3:0]                   wstrb;
    logic                         bvalid, rvalid;
    logic [1:0]                   bresp, rresp;
    logic [31:0]                  rdata;
  } lcad_state_s;

  lcad_state_s q_ff;
  lcad_state_s nxt_q;

  function automatic lcad_cmd_e decode_cmd(input logic [3:0] c);
    lcad_cmd_e r;
    r = CMD_NOP;
    if (!c[0]) begin
      if (c[1]) r = CMD_ACT;
      else if (!c[2]) r = c[3] ? CMD_MRR : CMD_MRW;
      else if (c[3]) r = CMD_REF;
    end else if (!c[1]) begin
      r = c[2] ? CMD_RD : CMD_WR;
    end else if (!c[2]) begin
      r = c[3] ? CMD_PRE : CMD_BST;
    end
    return r;
  endfunction

  function automatic logic [BANKS-1:0] bank_mask(input logic [BA_W-1:0] b);
    return BANKS'(1) << b;
  endfunction

  function automatic logic [BCNT_W-1:0] bl_beats(input logic [1:0] code);
    case (code)
      2'h0:    return BL4;
      2'h1:    return BL8;
      default: return BL16;
    endcase
  endfunction

  logic             ck_rise, ck_fall;
  logic [LANES-1:0] dqs_edge;
  logic             aw_take, w_take, ar_take;
  logic [31:0]      rd_mux;
  logic             rd_hit;

  assign ck_rise  = q_ff.ck_s & ~q_ff.ck_d;
  assign ck_fall  = ~q_ff.ck_s & q_ff.ck_d;
  assign dqs_edge = q_ff.dqs_s ^ q_ff.dqs_d;
  assign aw_take  = s_axi_awvalid & s_axi_awready;
  assign w_take   = s_axi_wvalid & s_axi_wready;
  assign ar_take  = s_axi_arvalid & s_axi_arready;

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0;
    case (s_axi_araddr)
      OFS_CTRL: begin
        rd_mux[CTRL_EN_POS] = q_ff.ctrl_en;
        rd_mux[CTRL_BL_LSB +: 2] = q_ff.ctrl_bl;
      end
      OFS_STATUS: begin
        rd_mux[ST_PWR_LSB +: 2] = q_ff.pwr;
        rd_mux[ST_OPEN_LSB +: BANKS] = q_ff.open;
        rd_mux[ST_BUR_LSB +: 2] = q_ff.bur;
        rd_mux[ST_CKE_POS] = q_ff.cke_r;
      end
      OFS_CMD: begin
        rd_mux[3:0] = q_ff.cmd;
        rd_mux[CMD_BA_LSB +: BA_W] = q_ff.bank;
        rd_mux[CMD_COL_LSB +: COL_W] = q_ff.col;
        rd_mux[CMD_AP_POS] = q_ff.ap;
      end
      OFS_ROW: begin
        rd_mux[ROW_W-1:0] = q_ff.row;
        rd_mux[ROW_BA_LSB +: BA_W] = q_ff.row_bank;
      end
      OFS_MODE: begin
        rd_mux[7:0] = q_ff.mra;
        rd_mux[MODE_OP_LSB +: 8] = q_ff.mrop;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    nxt_q = q_ff;
    // Two flops on every pin from the controller's clock domain
    nxt_q.ck_m  = ck;
    nxt_q.ck_s  = q_ff.ck_m;
    nxt_q.ck_d  = q_ff.ck_s;
    nxt_q.cke_m = cke;
    nxt_q.cke_s = q_ff.cke_m;
    nxt_q.cs_m  = cs_n;
    nxt_q.cs_s  = q_ff.cs_m;
    nxt_q.ca_m  = ca;
    nxt_q.ca_s  = q_ff.ca_m;
    nxt_q.dqs_m = dqs_i;
    nxt_q.dqs_s = q_ff.dqs_m;
    nxt_q.dqs_d = q_ff.dqs_s;
    nxt_q.dq_m  = dq_i;
    nxt_q.dq_s  = q_ff.dq_m;
    nxt_q.dm_m  = dm;
    nxt_q.dm_s  = q_ff.dm_m;
    nxt_q.cmd_vld = 1'b0;
    nxt_q.pre_vld = 1'b0;
    nxt_q.wr_vld  = 1'b0;
    nxt_q.wr_be   = '0;
    nxt_q.rd_req  = 1'b0;

    if (ck_rise) begin
      nxt_q.ca_r  = q_ff.ca_s;
      nxt_q.cs_r  = q_ff.cs_s;
      nxt_q.cke_r = q_ff.cke_s;
      nxt_q.cke_p = q_ff.cke_r;
      unique case (q_ff.pwr)
        PWR_ON: begin
          if (q_ff.cke_r && !q_ff.cke_s) begin
            if (q_ff.cs_s) nxt_q.pwr = PWR_PD;
            else if (q_ff.ca_s[2:0] == 3'h4) nxt_q.pwr = PWR_SR;
            else if (q_ff.ca_s[2:0] == 3'h3) nxt_q.pwr = PWR_DPD;
            else nxt_q.pwr = PWR_PD;
          end
        end
        PWR_PD: if (q_ff.cke_s && q_ff.cs_s) nxt_q.pwr = PWR_ON;
        PWR_SR, PWR_DPD: ;
      endcase
    end

    // Deep states leave on the CKE level alone, since CK may be stopped
    if ((q_ff.pwr == PWR_SR || q_ff.pwr == PWR_DPD) && q_ff.cke_s) begin
      nxt_q.pwr   = PWR_ON;
      nxt_q.cke_r = 1'b1;
      nxt_q.cke_p = 1'b1;
    end
    if (q_ff.pwr == PWR_DPD) nxt_q.open = '0;

    // Read beats: low half on the rise, high half on the fall
    if (ck_rise) begin
      if (q_ff.bur == BUR_RD && q_ff.bcnt != bl_beats(q_ff.ctrl_bl)) begin
        nxt_q.rdw    = rd_word;
        nxt_q.dq_o   = rd_word[DQ_W-1:0];
        nxt_q.dqs_o  = 1'b1;
        nxt_q.dq_oe  = q_ff.cke_s;
        nxt_q.rd_req = 1'b1;
        nxt_q.bcnt   = q_ff.bcnt + BCNT_W'(1);
      end else begin
        nxt_q.dq_oe = 1'b0;
        nxt_q.dqs_o = 1'b0;
        if (q_ff.bur == BUR_RD) begin
          nxt_q.bur = BUR_IDLE;
          if (q_ff.bap) begin
            nxt_q.pre_vld  = 1'b1;
            nxt_q.pre_mask = bank_mask(q_ff.bbank);
            nxt_q.open     = q_ff.open & ~bank_mask(q_ff.bbank);
          end
        end
      end
    end
    if (ck_fall && q_ff.bur == BUR_RD && q_ff.dq_oe) begin
      nxt_q.dq_o   = q_ff.rdw[2*DQ_W-1:DQ_W];
      nxt_q.dqs_o  = 1'b0;
      nxt_q.bcnt   = q_ff.bcnt + BCNT_W'(1);
      nxt_q.rd_col = q_ff.bcol + COL_W'(q_ff.bcnt + BCNT_W'(1));
    end

    // Write beats follow each strobe edge; masked lanes carry no enable
    if (q_ff.bur == BUR_WR && q_ff.cke_r && |dqs_edge) begin
      nxt_q.wr_vld  = 1'b1;
      nxt_q.wr_data = q_ff.dq_s;
      for (int i = 0; i < LANES; i++) begin
        nxt_q.wr_be[i] = dqs_edge[i] & ~q_ff.dm_s[i];
      end
      nxt_q.wr_col = q_ff.bcol + COL_W'(q_ff.bcnt);
      if (dqs_edge[0]) begin
        nxt_q.bcnt = q_ff.bcnt + BCNT_W'(1);
        if (q_ff.bcnt + BCNT_W'(1) == bl_beats(q_ff.ctrl_bl)) begin
          nxt_q.bur = BUR_IDLE;
          if (q_ff.bap) begin
            nxt_q.pre_vld  = 1'b1;
            nxt_q.pre_mask = bank_mask(q_ff.bbank);
            nxt_q.open     = q_ff.open & ~bank_mask(q_ff.bbank);
          end
        end
      end
    end

    // Command completes at the falling edge that brings its second half
    if (ck_fall && q_ff.pwr == PWR_ON && q_ff.ctrl_en && q_ff.cke_r && q_ff.cke_p
        && !q_ff.cs_r && decode_cmd(q_ff.ca_r[3:0]) != CMD_NOP) begin
      nxt_q.cmd_vld = 1'b1;
      nxt_q.cmd     = decode_cmd(q_ff.ca_r[3:0]);
      unique case (decode_cmd(q_ff.ca_r[3:0]))
        CMD_MRW, CMD_MRR: begin
          nxt_q.mra = {q_ff.ca_s[1:0], q_ff.ca_r[9:4]};
          if (q_ff.ca_r[3:0] == 4'h0) nxt_q.mrop = q_ff.ca_s[9:2];
        end
        CMD_ACT: begin
          nxt_q.row = {q_ff.ca_r[6:2], q_ff.ca_s[7:0]};
          nxt_q.row_bank = q_ff.ca_r[8:7];
          nxt_q.open[q_ff.ca_r[8:7]] = 1'b1;
          nxt_q.rows[q_ff.ca_r[8:7]] = {q_ff.ca_r[6:2], q_ff.ca_s[7:0]};
        end
        CMD_RD, CMD_WR: begin
          nxt_q.bank  = q_ff.ca_r[8:7];
          nxt_q.col   = {q_ff.ca_s[5:1], q_ff.ca_r[6:5], 1'b0};
          nxt_q.ap    = q_ff.ca_s[0];
          nxt_q.bbank = q_ff.ca_r[8:7];
          nxt_q.bap   = q_ff.ca_s[0];
          nxt_q.bcol  = {q_ff.ca_s[5:1], q_ff.ca_r[6:5], 1'b0};
          nxt_q.rd_col = {q_ff.ca_s[5:1], q_ff.ca_r[6:5], 1'b0};
          nxt_q.bcnt  = '0;
          nxt_q.bur   = q_ff.ca_r[2] ? BUR_RD : BUR_WR;
        end
        CMD_PRE: begin
          nxt_q.pre_vld  = 1'b1;
          nxt_q.bank     = q_ff.ca_r[8:7];
          nxt_q.pre_mask = q_ff.ca_r[4] ? '1 : bank_mask(q_ff.ca_r[8:7]);
          nxt_q.open     = nxt_q.open & ~(q_ff.ca_r[4] ? '1 : bank_mask(q_ff.ca_r[8:7]));
        end
        CMD_BST: begin
          nxt_q.bur   = BUR_IDLE;
          nxt_q.dq_oe = 1'b0;
          nxt_q.dqs_o = 1'b0;
        end
        CMD_REF, CMD_NOP: ;
      endcase
    end

    // Output drivers off whenever CKE was sampled low
    if (!q_ff.cke_r) begin
      nxt_q.dq_oe = 1'b0;
    end

    // Register bus: one write and one read in flight at most
    if (aw_take) begin
      nxt_q.aw_got = 1'b1;
      nxt_q.awaddr = s_axi_awaddr;
    end
    if (w_take) begin
      nxt_q.w_got = 1'b1;
      nxt_q.wdata = s_axi_wdata;
      nxt_q.wstrb = s_axi_wstrb;
    end
    if (q_ff.aw_got && q_ff.w_got) begin
      nxt_q.aw_got = 1'b0;
      nxt_q.w_got  = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp  = RESP_OKAY;
      unique case (q_ff.awaddr)
        OFS_CTRL: begin
          if (q_ff.wstrb[0]) begin
            nxt_q.ctrl_en = q_ff.wdata[CTRL_EN_POS];
            nxt_q.ctrl_bl = q_ff.wdata[CTRL_BL_LSB +: 2];
          end
        end
        OFS_STATUS, OFS_CMD, OFS_ROW, OFS_MODE: ;
        default: nxt_q.bresp = RESP_SLVERR;
      endcase
    end
    if (q_ff.bvalid && s_axi_bready) nxt_q.bvalid = 1'b0;
    if (ar_take) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata  = rd_mux;
      nxt_q.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (q_ff.rvalid && s_axi_rready) begin
      nxt_q.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff         <= '0;
      q_ff.pwr     <= PWR_ON;
      q_ff.bur     <= BUR_IDLE;
      q_ff.cmd     <= CMD_NOP;
      q_ff.ctrl_en <= CTRL_EN_RST;
      q_ff.ctrl_bl <= CTRL_BL_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign s_axi_awready = ~q_ff.aw_got & ~q_ff.bvalid;
  assign s_axi_wready  = ~q_ff.w_got & ~q_ff.bvalid;
  assign s_axi_bvalid  = q_ff.bvalid;
  assign s_axi_bresp   = q_ff.bresp;
  assign s_axi_arready = ~q_ff.rvalid;
  assign s_axi_rvalid  = q_ff.rvalid;
  assign s_axi_rdata   = q_ff.rdata;
  assign s_axi_rresp   = q_ff.rresp;

  assign dq_o       = q_ff.dq_o;
  assign dq_oe      = q_ff.dq_oe;
  assign dqs_o      = {LANES{q_ff.dqs_o}};
  assign dqs_oe     = {LANES{q_ff.dq_oe}};
  assign clk_active = q_ff.cke_r;
  assign pwr_state  = q_ff.pwr;
  assign cmd_valid  = q_ff.cmd_vld;
  assign cmd_code   = q_ff.cmd;
  assign cmd_bank   = q_ff.cmd == CMD_ACT ? q_ff.row_bank : q_ff.bank;
  assign cmd_row    = q_ff.row;
  assign cmd_col    = q_ff.col;
  assign cmd_ap     = q_ff.ap;
  assign mr_addr    = q_ff.mra;
  assign mr_op      = q_ff.mrop;
  assign pre_valid  = q_ff.pre_vld;
  assign pre_banks  = q_ff.pre_mask;
  assign wr_valid   = q_ff.wr_vld;
  assign wr_data    = q_ff.wr_data;
  assign wr_be      = q_ff.wr_be;
  assign wr_col     = q_ff.wr_col;
  assign burst_bank = q_ff.bbank;
  assign rd_req     = q_ff.rd_req;
  assign rd_col     = q_ff.rd_col;
endmodule

/* sim/lcad_asserts.sv */
// Port-level assertions for the command/address decoder
`timescale 1ns/1ps
module lcad_asserts (
  input logic                     aclk,
  input logic                     aresetn,
  input logic                     s_axi_awvalid,
  input logic                     s_axi_awready,
  input logic                     s_axi_wvalid,
  input logic                     s_axi_wready,
  input logic                     s_axi_bvalid,
  input logic                     s_axi_arvalid,
  input logic                     s_axi_arready,
  input logic                     s_axi_rvalid,
  input logic                     s_axi_rready,
  input logic [31:0]              s_axi_rdata,
  input logic                     cmd_valid,
  input logic [3:0]               cmd_code,
  input logic [lcad_pkg::COL_W-1:0] cmd_col,
  input logic                     rd_req,
  input logic [lcad_pkg::COL_W-1:0] rd_col,
  input logic                     dq_oe,
  input logic [3:0]               dqs_oe,
  input logic [3:0]               dqs_o,
  input logic [1:0]               pwr_state,
  input logic                     wr_valid,
  input logic                     pre_valid,
  input logic [3:0]               pre_banks
);
  import lcad_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("no write response");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("no read response");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_cmd_gap;
    cmd_valid |=> !cmd_valid [*8];
  endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("commands too close");
  property p_col_even;
    cmd_valid || rd_req |-> !(cmd_col[0] || rd_col[0]);
  endproperty
  a_col_even: assert property (p_col_even) else $error("odd column");
  property p_quiet;
    pwr_state != 2'h0 |-> !cmd_valid && !wr_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("activity while asleep");
  property p_rd_strobe;
    (dq_oe |-> dqs_oe == 4'hF) and (rd_req |-> dqs_o == 4'hF);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("strobe off");
  property p_pre_set;
    pre_valid |-> $onehot(pre_banks) || pre_banks == 4'hF;
  endproperty
  a_pre_set: assert property (p_pre_set) else $error("bad bank set");
  c_read: cover property (cmd_valid && cmd_code == CMD_RD);
  c_sr: cover property (pwr_state == 2'h3);
  c_pre_all: cover property (pre_valid && pre_banks == 4'hF);
endmodule

/* sim/lcad_host_model.sv */
// Behavioural memory controller driving the link pins
`timescale 1ns/1ps
module lcad_host_model (
  output logic        ck,
  output logic        cke,
  output logic        cs_n,
  output logic [9:0]  ca,
  output logic [31:0] dq_i,
  output logic [3:0]  dqs_i,
  output logic [3:0]  dm
);
  initial begin
    {ck, dqs_i, dm, dq_i} = '0;
    {cke, cs_n, ca} = '1;
  end
  // CK idles low between commands; CA held 12 ns around each edge
  task cmd(input logic k, s, input logic [9:0] r, f);
    #1 ca = r;
    cke = k;
    cs_n = s;
    #12 ck = 1'b1;
    #12 ca = f;
    #12 ck = 1'b0;
    #12 ca = ~f;
  endtask
  // Strobe centred in each data eye; lane 2 masked on beat mb, dq and dm inverted after the burst
  task wburst(input int n, input int mb);
    #1;
    for (int j = 0; j < n; j++) begin
      dq_i = {4{8'hA0 + 8'(j)}};
      dm = (j == mb) ? 4'h4 : 4'h0;
      #12 dqs_i = ~dqs_i;
      #12;
    end
    dq_i = ~dq_i;
    dm = ~dm;
  endtask
  task wake();
    #1 cke = 1'b1;
    cs_n = 1'b1;
  endtask
endmodule

/* sim/test_lpddr2_command_address_decoder.sv */
// Self-checking bench for the command/address decoder
`timescale 1ns/1ps
module test_lpddr2_command_address_decoder;
  import lcad_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, ck, cke, cs_n, dq_oe, clk_active, cmd_valid, cmd_ap;
  logic        pre_valid, wr_valid, rd_req, slo, shi;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pwr_state, cmd_bank, burst_bank;
  logic [3:0]  dqs_i, dqs_o, dqs_oe, dm, cmd_code, pre_banks, wr_be, pb;
  logic [3:0]  wb [16];
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cmd_col, mr_addr, mr_op, wr_col, rd_col;
  logic [9:0]  ca;
  logic [12:0] cmd_row;
  logic [31:0] s_axi_wdata, s_axi_rdata, dq_i, dq_o, wr_data;
  logic [31:0] wd [16];
  logic [63:0] rd_word;
  int          bad_count, n_checks, ncmd, nw, nr, i;
  lcad_decoder dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF), .*);
  lcad_host_model host (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (cmd_valid) ncmd <= ncmd + 1;
    if (wr_valid) begin
      wd[nw] <= wr_data;
      wb[nw] <= wr_be;
      nw <= nw + 1;
    end
    if (pre_valid) pb <= pre_banks;
    if (rd_req) nr <= nr + 1;
    if (dq_oe && dqs_o === 4'hF && dq_o === rd_word[31:0]) slo <= 1'b1;
    if (dq_oe && dqs_o === 4'h0 && dq_o === rd_word[63:32]) shi <= 1'b1;
  end
  task chk(input logic [63:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tmo();
    if (i >= 60) begin
      chk(1'b0, 1'b1);
      final_report();
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo();
    chk(s_axi_bresp, RESP_OKAY);
  endtask
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    tmo();
    chk({s_axi_rdata, s_axi_rresp}, {d, r});
  endtask
  // Refused commands simply run the wait out
  task send(input logic k, s, input logic [9:0] r, f, input int n);
    int n0;
    n0 = ncmd;
    host.cmd(k, s, r, f);
    for (i = 0; i < 8 && ncmd == n0; i++) @(posedge aclk);
    @(posedge aclk);
    chk(ncmd - n0, n);
  endtask
  task t_regs();
    axr(OFS_CTRL, 32'h3, RESP_OKAY);
    axr(8'h20, 32'h0, RESP_SLVERR);
    axw(OFS_CTRL, 32'h1);
    axr(OFS_CTRL, 32'h1, RESP_OKAY);
    $display("regs done");
  endtask
  task t_decode();
    // No high CKE at a previous rise since reset, so refused
    send(1, 0, 10'h2B0, 10'h172, 0);
    send(1, 0, 10'h2B0, 10'h172, 1);
    chk({cmd_code, mr_addr, mr_op}, {CMD_MRW, 16'hAB5C});
    send(1, 0, 10'h078, 10'h000, 1);
    chk(cmd_code, CMD_MRR);
    send(1, 0, 10'h00C, 10'h000, 1);
    chk(cmd_code, CMD_REF);
    send(1, 0, 10'h16A, 10'h0BC, 1);
    chk({cmd_code, cmd_bank, cmd_row}, {CMD_ACT, 2'h2, 13'h1ABC});
    send(1, 0, 10'h09B, 10'h000, 1);
    chk({cmd_code, pb}, {CMD_PRE, 4'hF});
    send(1, 1, 10'h16A, 10'h0BC, 0);
    send(1, 0, 10'h007, 10'h000, 0);
    $display("decode done");
  endtask
  task t_write();
    nw = 0;
    pb = 4'h0;
    send(1, 0, 10'h16A, 10'h0BC, 1);
    send(1, 0, 10'h161, 10'h00B, 1);
    chk({cmd_code, cmd_bank, cmd_col, cmd_ap}, {CMD_WR, 2'h2, 8'h2E, 1'b1});
    host.wburst(4, 1);
    for (i = 0; i < 60 && pb !== 4'h4; i++) @(posedge aclk);
    tmo();
    chk(nw, 4);
    chk({wb[0], wb[1]}, 8'hFB);
    chk(wd[3], 32'hA3A3A3A3);
    chk({burst_bank, wr_col}, {2'h2, 8'h31});
    $display("write done");
  endtask
  task t_read();
    send(1, 0, 10'h002, 10'h000, 1);
    {nr, slo, shi} = '0;
    send(1, 0, 10'h005, 10'h004, 1);
    chk({cmd_code, cmd_col}, {CMD_RD, 8'h10});
    repeat (3) host.cmd(1, 1, 10'h3FF, 10'h3FF);
    chk({nr, slo, shi}, {32'd2, 2'h3});
    chk(rd_col, 8'h14);
    axw(OFS_CTRL, 32'h5);
    send(1, 0, 10'h005, 10'h004, 1);
    nr = 0;
    send(1, 0, 10'h003, 10'h000, 1);
    chk(cmd_code, CMD_BST);
    repeat (2) host.cmd(1, 1, 10'h3FF, 10'h3FF);
    chk(nr, 1);
    $display("read done");
  endtask
  task wake_chk();
    host.wake();
    for (i = 0; i < 8 && pwr_state !== PWR_ON; i++) @(posedge aclk);
    chk(pwr_state, PWR_ON);
  endtask
  task t_power();
    send(0, 1, 10'h3FF, 10'h3FF, 0);
    chk({pwr_state, clk_active}, {PWR_PD, 1'b0});
    send(0, 0, 10'h005, 10'h004, 0);
    send(1, 1, 10'h3FF, 10'h3FF, 0);
    chk(pwr_state, PWR_ON);
    send(0, 0, 10'h004, 10'h3FF, 0);
    chk(pwr_state, PWR_SR);
    wake_chk();
    send(1, 1, 10'h3FF, 10'h3FF, 0);
    send(0, 0, 10'h003, 10'h3FF, 0);
    chk(pwr_state, PWR_DPD);
    wake_chk();
    $display("power done");
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    rd_word = 64'h89ABCDEF01234567;
    {bad_count, n_checks, ncmd, nw, nr, pb, slo, shi} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_decode();
    t_write();
    t_read();
    t_power();
    final_report();
  end
endmodule
bind lcad_decoder lcad_asserts u_chk (.*);
